// *** hbg_defines.svh ***
// Purpose: named constants of the H-bridge gate control block
// Assumes: included by bare name from the design files that use its macros
// Notes: times are in their own unit, cycle counts derive from them
`ifndef HBG_DEFINES_SVH
`define HBG_DEFINES_SVH

// clock rate and timing figures
`define HBG_CLK_MHZ 250
`define HBG_LIMIT_OFF_US 20
`define HBG_BLANK_NS 1000

// current thresholds in mA
`define HBG_LIMIT_NOM_MA 16'h1964
`define HBG_LIMIT_HOT_MA 16'h1068

// junction temperature points in degrees C, signed
`define HBG_HOT_C 10'sh0A0
`define HBG_OT_C 10'sh0AF
`define HBG_OT_HYST_C 10'sh00F

// synchronised pin bundle: bit positions and default levels
`define HBG_PIN_N 8
`define HBG_PIN_CMD_A 0
`define HBG_PIN_CMD_B 1
`define HBG_PIN_DIS_HI 2
`define HBG_PIN_DIS_LO 3
`define HBG_PIN_EN 4
`define HBG_PIN_SHORT 5
`define HBG_PIN_UV 6
`define HBG_PIN_SUPPLY 7
`define HBG_PIN_RST 8'h87

// register map, byte addresses
`define HBG_APB_AW 12
`define HBG_REG_LIMIT 12'h000
`define HBG_REG_STATUS 12'h004

// status word bit positions
`define HBG_ST_LATCH 0
`define HBG_ST_SHORT 1
`define HBG_ST_OT 2
`define HBG_ST_UV 3
`define HBG_ST_LIMIT 4
`define HBG_ST_BLANK 5
`define HBG_ST_HOT 6
`define HBG_ST_COOLWAIT 7
`define HBG_ST_FLAG 8
`define HBG_ST_SLEEP 9
`define HBG_ST_DRIVE 10

`endif

// *** hbg_pkg.sv ***
// Purpose: shared types of the H-bridge gate control block
// Assumes: nothing beyond the defines header
// Notes: state codes are one-hot
package hbg_pkg;
  typedef enum logic [2:0] {
    ST_SLEEP = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_LATCHED = 3'b100
  } hbg_state_t;
  typedef logic [15:0] hbg_ma_t;
  typedef logic signed [9:0] hbg_temp_t;
endpackage

// *** hbg_sync_if.sv ***
// Purpose: carries raw pin levels into the synchroniser and clean ones out
// Assumes: one clock domain on the clean side
// Notes: width set by the user
`timescale 1ns/1ps
`default_nettype none
interface hbg_sync_if #(parameter int W = 8);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface
`default_nettype wire

// *** hbg_sync.sv ***
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: raw levels are asynchronous to clk
// Notes: clean output moves only once stages two and three agree
`include "hbg_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module hbg_sync #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin bundle
  hbg_sync_if.sync port
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] clean_q;

  if (W < 1) begin : g_bad_w
    $error("synchroniser width must be at least one");
  end

  // per-bit agreement of the last two stages
  wire logic [W-1:0] agree = ~(s2_q ^ s3_q);

  // reset to the default levels a floating pin would show
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      clean_q <= RST_VAL;
    end else begin
      s1_q <= port.raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      clean_q <= (agree & s3_q) | (~agree & clean_q);
    end
  end

  assign port.clean = clean_q;

  // a stable pair is passed on one cycle later
  sync_agree_a: assert property (@(posedge clk) disable iff (rst)
    (s2_q == s3_q) |=> (clean_q == $past(s3_q)))
    else $error("synchroniser output ignored agreeing stages");
endmodule
`default_nettype wire

// *** hbg_timer.sv ***
// Purpose: loadable down counter used for off-time and blanking
// Assumes: load value at least one
// Notes: busy rises the cycle after start and lasts load cycles
`include "hbg_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module hbg_timer #(
  parameter int W = 16
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic start,
  input wire logic [W-1:0] load,
  // status
  output logic busy
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  if (W < 2 || W > 24) begin : g_bad_w
    $error("timer width out of range");
  end

  // restart wins over the running count
  assign cnt_d = start ? load : (cnt_q != '0) ? cnt_q - W'(1) : cnt_q;
  assign busy = (cnt_q != '0);

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_d_hold: cnt_q <= cnt_d;
    end
  end

  timer_load_a: assert property (@(posedge clk) disable iff (rst)
    (start && load != '0) |=> (busy && cnt_q == $past(load)))
    else $error("timer did not load");
  timer_count_a: assert property (@(posedge clk) disable iff (rst)
    (busy && !start) |=> (cnt_q == $past(cnt_q) - W'(1)))
    else $error("timer did not count down by one");
endmodule
`default_nettype wire

// *** hbg_gate_ctrl.sv ***
// Purpose: gate control and fault latch of an H-bridge driver, APB slave
// Assumes: clk 250 MHz; sensor words come from logic on clk
// Notes: bridge and flag pins are split into level and output enable
//
// What this block does
// - enabled, undisabled, fault-free: each output follows its command input
// - any disable input active: both outputs off, flag pulled low
// - undervoltage: outputs off, flag low; recovery restores both automatically
// - short or overtemperature latches outputs off and flag low
// - only disable, enable or supply toggles clear the latched fault
// - disable-high fall or disable-low rise clears a latch, flag high
// - current at threshold tri-states outputs for the fixed off-time
// - above 160 C the current threshold drops to 4.2 A
// - above 175 C overtemperature latches the outputs off
// - after clearing, outputs return only below trip minus hysteresis
// - supply power-down then power-up clears any latch, flag high
// - enable low means sleep: outputs off, flag released high
// - floating enable reads low, keeping sleep mode
// - each output transition starts a blanking window before short latch
//
// The register offsets and the APB register port were decided locally.
`include "hbg_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module hbg_gate_ctrl #(
  parameter int LIMIT_OFF_CYC = `HBG_LIMIT_OFF_US * `HBG_CLK_MHZ,
  parameter int BLANK_CYC = (`HBG_BLANK_NS * `HBG_CLK_MHZ + 999) / 1000,
  parameter int TMR_W = 16,
  parameter hbg_pkg::hbg_temp_t OT_HYST_C = `HBG_OT_HYST_C
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`HBG_APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host pins and fault detectors, asynchronous
  input wire logic bridge_cmd_a,
  input wire logic bridge_cmd_b,
  input wire logic disable_hi_active,
  input wire logic disable_lo_active,
  input wire logic enable_in,
  input wire logic supply_rail,
  input wire logic undervolt_det,
  input wire logic short_det,
  // sensor words on clk
  input wire hbg_pkg::hbg_ma_t load_current_ma,
  input wire hbg_pkg::hbg_temp_t junction_temp_c,
  // bridge outputs
  output logic bridge_out_a_o,
  output logic bridge_out_a_oe,
  output logic bridge_out_b_o,
  output logic bridge_out_b_oe,
  // open-drain fault flag
  output logic fault_flag_n_o,
  output logic fault_flag_n_oe
);
  import hbg_pkg::*;

  localparam hbg_temp_t OT_CLEAR_C = `HBG_OT_C - OT_HYST_C;

  if (LIMIT_OFF_CYC < 1 || LIMIT_OFF_CYC >= (1 << TMR_W)) begin : g_bad_off
    $error("limit off-time count does not fit the timer");
  end
  if (BLANK_CYC < 1 || BLANK_CYC >= (1 << TMR_W)) begin : g_bad_blank
    $error("blanking count does not fit the timer");
  end

  hbg_state_t st_q;
  hbg_state_t st_d;
  logic [`HBG_PIN_N-1:0] prev_q;
  logic hot_q;
  logic [1:0] cause_q;
  hbg_ma_t current_limit_threshold_q;
  logic off_busy;
  logic blank_busy;
  logic [31:0] status_w;

  // pin synchroniser, defaults match the pull resistors of the pads
  hbg_sync_if #(.W(`HBG_PIN_N)) pins ();
  assign pins.raw = {supply_rail, undervolt_det, short_det, enable_in,
                     disable_lo_active, disable_hi_active, bridge_cmd_b,
                     bridge_cmd_a};

  hbg_sync #(.W(`HBG_PIN_N), .RST_VAL(`HBG_PIN_RST)) u_sync (
    .clk(clk),
    .rst(rst),
    .port(pins.sync)
  );

  // named views of the clean pins
  wire logic cmd_a_s = pins.clean[`HBG_PIN_CMD_A];
  wire logic cmd_b_s = pins.clean[`HBG_PIN_CMD_B];
  wire logic dis_hi_s = pins.clean[`HBG_PIN_DIS_HI];
  wire logic dis_lo_s = pins.clean[`HBG_PIN_DIS_LO];
  wire logic en_s = pins.clean[`HBG_PIN_EN];
  wire logic short_s = pins.clean[`HBG_PIN_SHORT];
  wire logic uv_s = pins.clean[`HBG_PIN_UV];
  wire logic supply_s = pins.clean[`HBG_PIN_SUPPLY];

  // edges are taken on clean levels only, so glitches never clear a latch
  wire logic dis_hi_fall = prev_q[`HBG_PIN_DIS_HI] & ~dis_hi_s;
  wire logic dis_lo_rise = ~prev_q[`HBG_PIN_DIS_LO] & dis_lo_s;
  wire logic clr_evt = dis_hi_fall | dis_lo_rise;
  wire logic dis_any = dis_hi_s | ~dis_lo_s;
  wire logic powered_on = en_s & supply_s;

  // temperature comparisons; hot_q holds the cool-down wait
  wire logic hot160 = junction_temp_c > `HBG_HOT_C;
  wire logic ot_trip = junction_temp_c > `HBG_OT_C;
  wire logic cool = junction_temp_c < OT_CLEAR_C;
  wire logic hot_d = ot_trip | (hot_q & ~cool);

  // current limit: threshold folds back when hot
  wire hbg_ma_t limit_eff = hot160 ? `HBG_LIMIT_HOT_MA
                                   : current_limit_threshold_q;
  wire logic driving_q = bridge_out_a_oe | bridge_out_b_oe;
  wire logic over_cur = driving_q & (load_current_ma >= limit_eff);
  wire logic off_start = over_cur & ~off_busy;

  // a short inside the blanking window is only current limited
  wire logic short_hit = short_s & driving_q & ~blank_busy;
  wire logic fault_set = ot_trip | short_hit;

  // fault latch state machine; losing enable or supply always wins
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_SLEEP: begin
        if (powered_on) st_d = ST_ACTIVE;
      end
      ST_ACTIVE: begin
        if (fault_set) st_d = ST_LATCHED;
      end
      ST_LATCHED: begin
        if (clr_evt && !fault_set) st_d = ST_ACTIVE;
      end
      default: begin
        st_d = ST_SLEEP;
      end
    endcase
    if (!powered_on) st_d = ST_SLEEP;
  end

  // output decision for the next cycle
  wire logic drive_d = (st_d == ST_ACTIVE) & ~dis_any & ~uv_s & ~hot_d &
                       ~off_busy & ~off_start;
  wire logic out_a_d = drive_d & cmd_a_s;
  wire logic out_b_d = drive_d & cmd_b_s;
  wire logic flag_low_d = powered_on &
                          ((st_d == ST_LATCHED) | dis_any | uv_s);
  wire logic trans = (drive_d != driving_q) |
                     (drive_d & ((out_a_d != bridge_out_a_o) |
                                 (out_b_d != bridge_out_b_o)));
  wire logic latch_entry = (st_q != ST_LATCHED) & (st_d == ST_LATCHED);

  // off-time and blanking timers
  hbg_timer #(.W(TMR_W)) u_off (
    .clk(clk),
    .rst(rst),
    .start(off_start),
    .load(TMR_W'(LIMIT_OFF_CYC)),
    .busy(off_busy)
  );

  hbg_timer #(.W(TMR_W)) u_blank (
    .clk(clk),
    .rst(rst),
    .start(trans),
    .load(TMR_W'(BLANK_CYC)),
    .busy(blank_busy)
  );

  // state, pin history, cool-down and cause flags
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= ST_SLEEP;
      prev_q <= `HBG_PIN_RST;
      hot_q <= 1'b0;
      cause_q <= 2'b00;
    end else begin
      st_q <= st_d;
      prev_q <= pins.clean;
      hot_q <= hot_d;
      if (latch_entry) cause_q <= {ot_trip, short_hit};
      else if (st_d != ST_LATCHED) cause_q <= 2'b00;
    end
  end

  // pins are registered so the pads never see decode glitches
  always_ff @(posedge clk) begin
    if (rst) begin
      bridge_out_a_o <= 1'b0;
      bridge_out_a_oe <= 1'b0;
      bridge_out_b_o <= 1'b0;
      bridge_out_b_oe <= 1'b0;
      fault_flag_n_o <= 1'b0;
      fault_flag_n_oe <= 1'b0;
    end else begin
      bridge_out_a_o <= out_a_d;
      bridge_out_a_oe <= drive_d;
      bridge_out_b_o <= out_b_d;
      bridge_out_b_oe <= drive_d;
      fault_flag_n_o <= 1'b0; // open drain only ever pulls low
      fault_flag_n_oe <= flag_low_d;
    end
  end

  // apb decode; answers with no wait state
  wire logic apb_setup = psel & ~penable;
  wire logic apb_done = psel & penable & pready;
  wire logic hit_limit = (paddr == `HBG_REG_LIMIT);
  wire logic hit_status = (paddr == `HBG_REG_STATUS);
  wire logic addr_ok = hit_limit | hit_status;
  wire logic wr_limit = apb_done & pwrite & hit_limit & ~pslverr;
  wire hbg_ma_t thr_wr = {pstrb[1] ? pwdata[15:8]
                                   : current_limit_threshold_q[15:8],
                          pstrb[0] ? pwdata[7:0]
                                   : current_limit_threshold_q[7:0]};

  // status word built from live state
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[`HBG_ST_LATCH] = (st_q == ST_LATCHED);
    status_w[`HBG_ST_SHORT] = cause_q[0];
    status_w[`HBG_ST_OT] = cause_q[1];
    status_w[`HBG_ST_UV] = uv_s;
    status_w[`HBG_ST_LIMIT] = off_busy;
    status_w[`HBG_ST_BLANK] = blank_busy;
    status_w[`HBG_ST_HOT] = hot160;
    status_w[`HBG_ST_COOLWAIT] = hot_q;
    status_w[`HBG_ST_FLAG] = fault_flag_n_oe;
    status_w[`HBG_ST_SLEEP] = (st_q == ST_SLEEP);
    status_w[`HBG_ST_DRIVE] = driving_q;
  end

  wire logic [31:0] rd_word = hit_limit ? {16'h0000, current_limit_threshold_q}
                            : hit_status ? status_w : 32'h0000_0000;

  // read data is captured in setup so it is stable through the access
  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      current_limit_threshold_q <= `HBG_LIMIT_NOM_MA;
    end else begin
      pready <= apb_setup;
      prdata <= (apb_setup & ~pwrite) ? rd_word : 32'h0000_0000;
      pslverr <= apb_setup & ~addr_ok;
      if (wr_limit) current_limit_threshold_q <= thr_wr;
    end
  end

  // checks on the registered pins
  run_follow_a: assert property (@(posedge clk) disable iff (rst)
    (st_q == ST_ACTIVE && powered_on && !fault_set && !dis_any && !uv_s &&
     !hot_q && !off_busy && !over_cur) |=>
    (bridge_out_a_oe && bridge_out_b_oe &&
     bridge_out_a_o == $past(cmd_a_s) && bridge_out_b_o == $past(cmd_b_s)))
    else $error("outputs did not follow the commands");
  disable_off_a: assert property (@(posedge clk) disable iff (rst)
    (dis_any && powered_on) |=>
    (!bridge_out_a_oe && !bridge_out_b_oe && fault_flag_n_oe))
    else $error("disable did not tri-state and flag");
  uv_off_a: assert property (@(posedge clk) disable iff (rst)
    (uv_s && powered_on) |=> (!bridge_out_a_oe && fault_flag_n_oe))
    else $error("undervoltage not handled");
  fault_hold_a: assert property (@(posedge clk) disable iff (rst)
    (st_q == ST_LATCHED && powered_on && !clr_evt) |=>
    (st_q == ST_LATCHED && !bridge_out_a_oe && fault_flag_n_oe))
    else $error("latched fault released without a clearing edge");
  short_clear_a: assert property (@(posedge clk) disable iff (rst)
    (st_q == ST_LATCHED && dis_hi_fall && !fault_set && powered_on) |=>
    (st_q == ST_ACTIVE))
    else $error("disable edge did not clear the latch");
  limit_off_a: assert property (@(posedge clk) disable iff (rst)
    off_busy |-> (!bridge_out_a_oe && !bridge_out_b_oe))
    else $error("outputs driven during the off-time");
  hot_limit_a: assert property (@(posedge clk) disable iff (rst)
    (driving_q && hot160 && load_current_ma >= `HBG_LIMIT_HOT_MA &&
     !off_busy) |=> off_busy)
    else $error("hot threshold did not start the off-time");
  ot_latch_a: assert property (@(posedge clk) disable iff (rst)
    (ot_trip && st_q == ST_ACTIVE && powered_on) |=>
    (st_q == ST_LATCHED && fault_flag_n_oe && !bridge_out_a_oe))
    else $error("overtemperature did not latch");
  cool_wait_a: assert property (@(posedge clk) disable iff (rst)
    (hot_q && !cool) |=> (!bridge_out_a_oe && !bridge_out_b_oe))
    else $error("outputs on before cooling below hysteresis");
  power_clear_a: assert property (@(posedge clk) disable iff (rst)
    !supply_s |=> (st_q == ST_SLEEP && !fault_flag_n_oe))
    else $error("power-down did not clear the fault");
  sleep_mode_a: assert property (@(posedge clk) disable iff (rst)
    !en_s |=> (st_q == ST_SLEEP && !fault_flag_n_oe && !bridge_out_a_oe))
    else $error("sleep mode not entered");
  blank_short_a: assert property (@(posedge clk) disable iff (rst)
    (st_q == ST_ACTIVE && blank_busy && !ot_trip) |=> (st_q != ST_LATCHED))
    else $error("short latched inside the blanking window");
endmodule
`default_nettype wire

// *** hbg_host_model.sv ***
// Purpose: host controller model driving the bridge pins, reading the flag
// Assumes: pin changes land right after a rising clk edge
// Notes: flag wire is open drain with a pull-up, level worked out here
`timescale 1ns/1ps
`default_nettype none
module hbg_host_model (
  // clock
  input wire logic clk,
  // pin levels requested by the test, {cmd_a, cmd_b, dis_hi, dis_lo, en, supply}
  input wire logic [5:0] req,
  // pins towards the device
  output logic cmd_a,
  output logic cmd_b,
  output logic dis_hi,
  output logic dis_lo,
  output logic enable,
  output logic supply,
  // fault flag
  input wire logic flag_oe,
  output logic flag_lvl
);
  // pull-up wins unless the device sinks the line
  assign flag_lvl = ~flag_oe;
  // port latch takes a request on the next edge, like a gpio write;
  // toggles of these pins are how the host recovers a latched bridge
  always_ff @(posedge clk) begin
    {cmd_a, cmd_b, dis_hi, dis_lo, enable, supply} <= req;
  end
endmodule
`default_nettype wire

// *** hbridge_gate_control_fault_latch_tb_top.sv ***
// Purpose: self-checking bench of the bridge gate control block
// Assumes: short timer parameters so the run stays brief
// Notes: pin paths are given 8 edges to settle through the synchroniser
`include "hbg_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module hbridge_gate_control_fault_latch_tb_top;
  import hbg_pkg::*;
  localparam int OFF = 20;
  localparam logic [1:0] Z = 2'b00;
  localparam logic [1:0] H = 2'b11;
  localparam logic [1:0] L = 2'b10;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, uv, sc, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  hbg_ma_t cur;
  hbg_temp_t temp;
  logic ca, cb, dh, dl, en, sup, flag, ao, aoe, bo, boe, foe, fo;
  logic [5:0] hreq;
  logic [5:0] clr [4];
  int n_mismatch, cmp_count;
  hbg_host_model host (.clk(clk), .req(hreq), .cmd_a(ca), .cmd_b(cb),
    .dis_hi(dh), .dis_lo(dl), .enable(en), .supply(sup), .flag_oe(foe),
    .flag_lvl(flag));
  hbg_gate_ctrl #(.LIMIT_OFF_CYC(OFF), .BLANK_CYC(4)) DUT (.clk(clk),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bridge_cmd_a(ca),
    .bridge_cmd_b(cb), .disable_hi_active(dh), .disable_lo_active(dl),
    .enable_in(en), .supply_rail(sup), .undervolt_det(uv),
    .short_det(sc), .load_current_ma(cur), .junction_temp_c(temp),
    .bridge_out_a_o(ao), .bridge_out_a_oe(aoe), .bridge_out_b_o(bo),
    .bridge_out_b_oe(boe), .fault_flag_n_o(fo), .fault_flag_n_oe(foe));
  // free-running 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // verdict and end of run
  task automatic final_report();
    if (n_mismatch == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // host pin request {cmd_a, cmd_b, dis_hi, dis_lo, enable, supply}
  task automatic drive(input logic [5:0] v);
    hreq <= v;
  endtask
  // compare bridge outputs {oe,o}, the open-drain level and the flag wire
  task automatic chk_out(input logic [1:0] ea, eb, input logic ef);
    cmp_count++;
    if ({aoe, ao, boe, bo, fo, flag} !== {ea, eb, 1'b0, ef}) begin
      n_mismatch++;
      $display("Error bridge exp %b got %b", {ea, eb, 1'b0, ef},
        {aoe, ao, boe, bo, fo, flag});
    end
  endtask
  task automatic chk_reg(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s exp %h got %h", nm, e, g);
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [3:0] s);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && k < 50) begin
      k++;
      @(posedge clk);
    end
    if (k == 50) n_mismatch++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // a hang ends the run as a failure
  initial begin
    wt(20000);
    n_mismatch++;
    final_report();
  end
  // test sequence
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, uv, sc} = 5'b0_0000;
    hreq = 6'b11_0101; // start in sleep with safe command levels
    paddr = '0;
    pwdata = '0;
    pstrb = '0;
    cur = '0;
    temp = 10'sh019;
    n_mismatch = 0;
    cmp_count = 0;
    clr = '{6'b01_1111, 6'b01_0011, 6'b01_0101, 6'b01_0110};
    wt(6);
    rst <= 1'b0;
    wt(8);
    chk_out(Z, Z, 1'b1);
    apb(1'b0, `HBG_REG_LIMIT, '0, '0);
    chk_reg("limit", 32'h0000_1964, rd);
    // command truth table while enabled
    for (int i = 0; i < 4; i++) begin
      drive({i[1], i[0], 4'b0111});
      wt(8);
      chk_out({1'b1, i[1]}, {1'b1, i[0]}, 1'b1);
    end
    drive(6'b10_1111);
    wt(8);
    chk_out(Z, Z, 1'b0);
    drive(6'b10_0011);
    wt(8);
    chk_out(Z, Z, 1'b0);
    drive(6'b10_0111);
    uv <= 1'b1;
    wt(8);
    chk_out(Z, Z, 1'b0);
    uv <= 1'b0;
    wt(8);
    chk_out(H, L, 1'b1);
    // short latch, cleared by each of the four toggles
    for (int m = 0; m < 4; m++) begin
      drive(6'b10_0111);
      wt(8);
      sc <= 1'b1;
      wt(8);
      chk_out(Z, Z, 1'b0);
      apb(1'b0, `HBG_REG_STATUS, '0, '0);
      chk_reg("status", 32'h0000_0003, rd & 32'h0000_0003);
      drive(6'b01_0111);
      sc <= 1'b0;
      wt(8);
      chk_out(Z, Z, 1'b0);
      drive(clr[m]);
      wt(8);
      drive(6'b01_0111);
      wt(8);
      chk_out(L, H, 1'b1);
    end
    // current limit off-time and threshold edge
    cur <= 16'h1963;
    wt(3);
    chk_out(L, H, 1'b1);
    cur <= 16'h1964;
    wt(1);
    cur <= '0;
    wt(3);
    chk_out(Z, Z, 1'b1);
    wt(OFF - 2);
    chk_out(Z, Z, 1'b1);
    wt(4);
    chk_out(L, H, 1'b1);
    cur <= 16'h1068;
    temp <= `HBG_HOT_C;
    wt(3);
    chk_out(L, H, 1'b1);
    temp <= `HBG_HOT_C + 10'sh001;
    wt(2);
    cur <= '0;
    wt(2);
    chk_out(Z, Z, 1'b1);
    wt(OFF + 2);
    chk_out(L, H, 1'b1);
    // overtemperature latch and cool-down
    temp <= `HBG_OT_C + 10'sh001;
    wt(4);
    chk_out(Z, Z, 1'b0);
    temp <= `HBG_OT_C - 10'sh005;
    drive(6'b01_1111);
    wt(8);
    drive(6'b01_0111);
    wt(8);
    chk_out(Z, Z, 1'b1);
    temp <= `HBG_OT_C - `HBG_OT_HYST_C - 10'sh001;
    wt(8);
    chk_out(L, H, 1'b1);
    // short seen inside the blanking window of a transition latches only after the window ends
    drive(6'b10_0111);
    wt(2);
    sc <= 1'b1;
    wt(7);
    chk_out(H, L, 1'b1);
    wt(6);
    chk_out(Z, Z, 1'b0);
    sc <= 1'b0;
    drive(6'b10_1111);
    wt(8);
    drive(6'b10_0111);
    wt(8);
    chk_out(H, L, 1'b1);
    // register access kinds
    apb(1'b1, `HBG_REG_LIMIT, 32'h1234_ABCD, 4'b0001);
    apb(1'b0, `HBG_REG_LIMIT, '0, '0);
    chk_reg("limit_wr", 32'h0000_19CD, rd);
    apb(1'b1, `HBG_REG_LIMIT, 32'h0000_5A64, 4'b0010);
    apb(1'b0, `HBG_REG_LIMIT, '0, '0);
    chk_reg("limit_hi", 32'h0000_5ACD, rd);
    apb(1'b1, `HBG_REG_STATUS, 32'hFFFF_FFFF, 4'b1111);
    chk_reg("status_err", 32'h0000_0000, {31'h0, er});
    apb(1'b0, 12'h008, '0, '0);
    chk_reg("unmapped", 32'h0000_0001, {rd[31:1], er});
    final_report();
  end
endmodule
`default_nettype wire
